// ==== hw/lss_pkg.sv ====
// Package: constants, field layouts and helpers for the LED sink output control block
package lss_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_CH     = 48;
  localparam int SHIFT_W    = 49;
  localparam int GROUP_W    = 16;
  localparam int BRIGHT_W   = 7;
  localparam int PEAK_W     = 3;
  localparam int FUNC_W     = 37;

  // ****************************************
  // Shift register fields
  // ****************************************
  localparam int         SEL_BIT       = 48;
  localparam int         CMD_MSB       = 47;
  localparam int         CMD_LSB       = 40;
  localparam logic [7:0] WRITE_CMD     = 8'h96;
  localparam int         FUNC_LSB      = 3;
  // Offsets inside the 37-bit function latch
  localparam int         PEAK_LSB      = 0;
  localparam int         BRIGHT_R_LSB  = 3;
  localparam int         BRIGHT_G_LSB  = 10;
  localparam int         BRIGHT_B_LSB  = 17;
  localparam int         PS_SEL_LSB    = 24;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [PEAK_W-1:0]   PEAK_RST   = 3'h0;
  localparam logic [BRIGHT_W-1:0] BRIGHT_RST = 7'h7F;
  localparam logic [1:0]          PS_SEL_RST = 2'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int         CLK_NS        = 40;
  localparam int         STEP_NS       = 160;
  localparam int         STEP_CYC      = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] STEP_RST      = 8'(STEP_CYC);

  // ****************************************
  // APB register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_ONOFF_LO = 8'h04;
  localparam logic [7:0] ADDR_ONOFF_HI = 8'h08;
  localparam logic [7:0] ADDR_BRIGHT   = 8'h0C;
  localparam logic [7:0] ADDR_STEP     = 8'h10;

  typedef enum logic {PS_NORMAL = 1'b0, PS_SAVE = 1'b1} lss_ps_e;

  // Sequence position to channel bit: pairs 0,15,1,14,... each red, green, blue
  function automatic logic [5:0] lss_seq_chan(input logic [5:0] pos);
    logic [4:0] pair;
    logic [1:0] col;
    logic [3:0] idx;
    pair = 5'(pos / 6'h3);
    col  = 2'(pos % 6'h3);
    idx  = pair[0] ? (4'hF - pair[4:1]) : pair[4:1];
    return 6'(6'(idx) * 6'h3 + 6'(col));
  endfunction : lss_seq_chan

endpackage : lss_pkg

// ==== hw/lss_sync.sv ====
// Two-flop synchroniser with edge detection for one pin
module lss_sync
  import lss_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta;
  logic prev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta  <= 1'b0;
      level <= 1'b0;
      prev  <= 1'b0;
    end else begin
      meta  <= din;
      level <= meta;
      prev  <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule : lss_sync

// ==== hw/lss_stagger.sv ====
// Staggered channel switcher: copies target bits to outputs one channel per tick
module lss_stagger
  import lss_pkg::*;
#(
  parameter int N = NUM_CH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic         clear,
  input  wire logic         tick,
  input  wire logic [N-1:0] target,
  output logic      [N-1:0] state,
  output logic              busy
);
  logic [5:0] pos;
  logic [5:0] ch;

  assign ch = lss_seq_chan(pos);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos   <= 6'h0;
      busy  <= 1'b0;
      state <= '0;
    end else if (start) begin
      // A new trigger restarts from the first channel
      pos  <= 6'h0;
      busy <= 1'b1;
      if (clear) begin
        state <= '0;
      end
    end else if (clear) begin
      // Outputs are forced dark, so the next start must step up from all off
      state <= '0;
      busy  <= 1'b0;
    end else if (busy && tick) begin
      state[ch] <= target[ch];
      if (pos == 6'(N - 1)) begin
        busy <= 1'b0;
      end else begin
        pos <= pos + 6'h1;
      end
    end
  end
endmodule : lss_stagger

// ==== hw/lss_top.sv ====
// Top: output control, peak/brightness latches and power save for a 48-channel sink
//
// Summary of operation
// - Channels switch one per step: index 0,15,1,14,... each red, green, blue.
// - Blank falling or latch strobe rising starts the sequence, for on and off.
// - Peak current code changes only after two successive equal writes.
// - Peak current code is zero after reset, lowest current step.
// - Peak current code is three bits; 111 is the highest step.
// - Each colour group of sixteen channels has its own brightness code.
// - Brightness code is seven bits, 7Fh full current, 00h lowest.
// - A newly latched brightness code drives the outputs at once.
// - Blank low: each channel follows its on/off latch bit.
// - Blank high forces all channels off; latch contents are kept.
// - All 48 on/off latch bits clear to zero at reset.
// - Power-save select bits live in the brightness/function latch.
// - Power save disables sinks and fault detection; logic keeps working.
// - Select 11b always power save; 00b always normal.
// - Select 01b: entering power save on an all-zero on/off write; 10b only if the on/off latch already held zero.
// - Select 01b: a shift clock rising edge leaves power save.
// - Select 10b: any nonzero on/off latch bit leaves power save.
// - Latch strobe rise with top bit 0 loads on/off latch from bits 47:0.
// - Function writes need top bit 1 and command byte 96h.
module lss_top
  import lss_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [7:0]          paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                shift_clk,
  input  wire logic                serial_in,
  input  wire logic                latch_strobe,
  input  wire logic                blank,
  output logic      [NUM_CH-1:0]   sink_channel,
  output logic      [PEAK_W-1:0]   peak_current_code,
  output logic      [BRIGHT_W-1:0] red_brightness_code,
  output logic      [BRIGHT_W-1:0] green_brightness_code,
  output logic      [BRIGHT_W-1:0] blue_brightness_code,
  output logic                     power_save_state,
  output logic                     fault_detect_en
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic sclk_lvl;
  logic sclk_rise;
  logic sin_lvl;
  logic latch_lvl;
  logic latch_rise;
  logic blank_lvl;
  logic blank_fall;

  lss_sync u_sync_sclk (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (shift_clk),
    .level (sclk_lvl),
    .rise  (sclk_rise),
    .fall  ()
  );

  // Data takes the same two-flop delay as its clock, so they stay aligned
  lss_sync u_sync_sin (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (serial_in),
    .level (sin_lvl),
    .rise  (),
    .fall  ()
  );

  lss_sync u_sync_latch (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (latch_strobe),
    .level (latch_lvl),
    .rise  (latch_rise),
    .fall  ()
  );

  lss_sync u_sync_blank (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (blank),
    .level (blank_lvl),
    .rise  (),
    .fall  (blank_fall)
  );

  // ****************************************
  // Common shift register
  // ****************************************
  logic [SHIFT_W-1:0] shift_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= '0;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[SHIFT_W-2:0], sin_lvl};
    end
  end

  // ****************************************
  // Latch decode
  // ****************************************
  logic onoff_load;
  logic func_load;

  assign onoff_load = latch_rise & ~shift_reg[SEL_BIT];
  assign func_load  = latch_rise & shift_reg[SEL_BIT]
                    & (shift_reg[CMD_MSB:CMD_LSB] == WRITE_CMD);

  // ****************************************
  // On/off latch
  // ****************************************
  logic [NUM_CH-1:0] onoff_latch;
  logic              zero_written;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      onoff_latch <= '0;
    end else if (onoff_load) begin
      onoff_latch <= shift_reg[NUM_CH-1:0];
    end
  end

  assign zero_written = onoff_load & (shift_reg[NUM_CH-1:0] == '0);

  // ****************************************
  // Brightness and function latch
  // ****************************************
  logic [FUNC_W-1:0] func_word;
  logic [PEAK_W-1:0] peak_new;
  logic [PEAK_W-1:0] peak_pending;
  logic              peak_pending_vld;
  logic [1:0]        power_save_select;

  assign func_word = shift_reg[FUNC_LSB +: FUNC_W];
  assign peak_new  = func_word[PEAK_LSB +: PEAK_W];

  // Brightness codes apply straight away on the latch edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      red_brightness_code   <= BRIGHT_RST;
      green_brightness_code <= BRIGHT_RST;
      blue_brightness_code  <= BRIGHT_RST;
    end else if (func_load) begin
      red_brightness_code   <= func_word[BRIGHT_R_LSB +: BRIGHT_W];
      green_brightness_code <= func_word[BRIGHT_G_LSB +: BRIGHT_W];
      blue_brightness_code  <= func_word[BRIGHT_B_LSB +: BRIGHT_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_save_select <= PS_SEL_RST;
    end else if (func_load) begin
      power_save_select <= func_word[PS_SEL_LSB +: 2];
    end
  end

  // Guards against a single corrupted frame changing the current range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peak_current_code <= PEAK_RST;
      peak_pending      <= PEAK_RST;
      peak_pending_vld  <= 1'b0;
    end else if (func_load) begin
      peak_pending     <= peak_new;
      peak_pending_vld <= 1'b1;
      if (peak_pending_vld && (peak_pending == peak_new)) begin
        peak_current_code <= peak_new;
      end
    end
  end

  // ****************************************
  // Power-save state
  // ****************************************
  lss_ps_e ps_state;
  lss_ps_e next_ps_state;
  logic    ps_exit;

  always_comb begin
    next_ps_state = ps_state;
    case (power_save_select)
      2'h0: next_ps_state = PS_NORMAL;
      2'h3: next_ps_state = PS_SAVE;
      2'h1: begin
        if (zero_written) begin
          next_ps_state = PS_SAVE;
        end else if (sclk_rise) begin
          next_ps_state = PS_NORMAL;
        end
      end
      2'h2: begin
        if (onoff_latch != '0) begin
          next_ps_state = PS_NORMAL;
        end else if (zero_written) begin
          next_ps_state = PS_SAVE;
        end
      end
      default: next_ps_state = PS_NORMAL;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_state <= PS_NORMAL;
    end else begin
      ps_state <= next_ps_state;
    end
  end

  assign ps_exit = (ps_state == PS_SAVE) && (next_ps_state == PS_NORMAL);

  // Sinks and fault detection are idle in power save; latches keep running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_save_state <= 1'b0;
      fault_detect_en  <= 1'b1;
    end else begin
      power_save_state <= (next_ps_state == PS_SAVE);
      fault_detect_en  <= (next_ps_state == PS_NORMAL);
    end
  end

  // ****************************************
  // Step divider
  // ****************************************
  logic [7:0] step_cycles;
  logic [7:0] step_cnt;
  logic       step_tick;

  assign step_tick = (step_cnt == 8'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt <= 8'h0;
    end else if (step_tick) begin
      step_cnt <= (step_cycles == 8'h0) ? 8'h0 : step_cycles - 8'h1;
    end else begin
      step_cnt <= step_cnt - 8'h1;
    end
  end

  // ****************************************
  // Staggered switching
  // ****************************************
  logic              seq_start;
  logic              seq_busy;
  logic [NUM_CH-1:0] seq_state;

  // Power-save exit also restarts so outputs come back in order
  assign seq_start = blank_fall | latch_rise | ps_exit;

  lss_stagger #(
    .N (NUM_CH)
  ) u_stagger (
    .clk    (pclk),
    .rst_n  (presetn),
    .start  (seq_start),
    .clear  (blank_lvl || (ps_state == PS_SAVE)),
    .tick   (step_tick),
    .target (onoff_latch),
    .state  (seq_state),
    .busy   (seq_busy)
  );

  // Blank and power save cut all sinks at once, not staggered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sink_channel <= '0;
    end else if (blank_lvl || (ps_state == PS_SAVE)) begin
      sink_channel <= '0;
    end else begin
      sink_channel <= seq_state;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  logic        apb_setup;
  logic        apb_write;
  logic        addr_ok;
  logic [31:0] next_prdata;

  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pready & pwrite;

  always_comb begin
    next_prdata = 32'h0;
    addr_ok     = 1'b1;
    case (paddr)
      ADDR_STATUS: begin
        next_prdata = {25'h0, power_save_select, peak_current_code,
                       seq_busy, power_save_state};
      end
      ADDR_ONOFF_LO: next_prdata = onoff_latch[31:0];
      ADDR_ONOFF_HI: next_prdata = {16'h0, onoff_latch[47:32]};
      ADDR_BRIGHT: begin
        next_prdata = {9'h0, blue_brightness_code, 1'b0,
                       green_brightness_code, 1'b0, red_brightness_code};
      end
      ADDR_STEP:     next_prdata = {24'h0, step_cycles};
      default:       addr_ok     = 1'b0;
    endcase
  end

  // Zero wait states: answer is ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~addr_ok;
      if (apb_setup && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cycles <= STEP_RST;
    end else if (apb_write && (paddr == ADDR_STEP)) begin
      step_cycles <= pwdata[7:0];
    end
  end

endmodule : lss_top

// ==== bench/lss_props.sv ====
// Checker: port-level properties of the LED sink output control block
module lss_props
  import lss_pkg::*;
(
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic [7:0]          paddr,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                shift_clk,
  input wire logic                serial_in,
  input wire logic                latch_strobe,
  input wire logic                blank,
  input wire logic [NUM_CH-1:0]   sink_channel,
  input wire logic [PEAK_W-1:0]   peak_current_code,
  input wire logic [BRIGHT_W-1:0] red_brightness_code,
  input wire logic [BRIGHT_W-1:0] green_brightness_code,
  input wire logic [BRIGHT_W-1:0] blue_brightness_code,
  input wire logic                power_save_state,
  input wire logic                fault_detect_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // Properties
  // ****************************************
  a_blank_off:
    assert property (blank[*6] |-> sink_channel == 48'h0) else $error("sink on while blanked");
  a_save_off:
    assert property (power_save_state[*2] |-> sink_channel == 48'h0)
    else $error("sink on in power save");
  a_fault_gate:
    assert property ($stable(power_save_state) |-> fault_detect_en != power_save_state)
    else $error("fault detect wrong for power state");
  a_peak_quiet:
    assert property (!latch_strobe[*8] |-> $stable(peak_current_code))
    else $error("peak code moved without latch");
  a_bright_quiet:
    assert property (!latch_strobe[*8] |-> $stable({red_brightness_code,
      green_brightness_code, blue_brightness_code})) else $error("brightness moved");
  a_one_step:
    assert property ((!blank && !power_save_state)[*8]
      |-> $onehot0(sink_channel ^ $past(sink_channel))) else $error("several channels at once");
  a_ready_next:
    assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_only:
    assert property (pready |-> psel && penable) else $error("ready outside access");
  a_err_unmapped:
    assert property (psel && !penable && paddr > 8'h10 |=> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
endmodule : lss_props

bind lss_top lss_props u_props (.*);

// ==== bench/lss_ctl_model.sv ====
// Display controller model: serial link, latch strobe and blanking pin
module lss_ctl_model (
  input  wire logic clk,
  output logic      shift_clk,
  output logic      serial_in,
  output logic      latch_strobe,
  output logic      blank
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    shift_clk = 1'b0;
    serial_in = 1'b0;
    latch_strobe = 1'b0;
    blank = 1'b1;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc
  // Link clock stands low between frames; 320 ns period
  task automatic pulse_clk();
    wait_cyc(4);
    shift_clk <= 1'b1;
    wait_cyc(4);
    shift_clk <= 1'b0;
  endtask : pulse_clk
  task automatic send(input logic [48:0] w);
    for (int i = 48; i >= 0; i--) begin
      serial_in <= w[i];
      pulse_clk();
    end
    // Data line after the frame shows no stale bit
    serial_in <= ~w[0];
    latch_strobe <= 1'b1;
    wait_cyc(4);
    latch_strobe <= 1'b0;
    wait_cyc(8);
  endtask : send
  // Blank moves only on request, so it stays low over power save exits
  task automatic set_blank(input logic v);
    blank <= v;
    wait_cyc(1);
  endtask : set_blank
endmodule : lss_ctl_model

// ==== bench/test_lss_top.sv ====
// Testbench: serial link, APB and power save scenarios for lss_top
module test_lss_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lss_pkg::*;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, e;
  logic shift_clk, serial_in, latch_strobe, blank, ps, fde;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [NUM_CH-1:0] sink;
  logic [PEAK_W-1:0] peak;
  logic [BRIGHT_W-1:0] rb, gb, bb;
  int bad_count = 0;
  int compares = 0;
  always #20 pclk = ~pclk;
  lss_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shift_clk(shift_clk), .serial_in(serial_in),
    .latch_strobe(latch_strobe), .blank(blank), .sink_channel(sink),
    .peak_current_code(peak), .red_brightness_code(rb), .green_brightness_code(gb),
    .blue_brightness_code(bb), .power_save_state(ps), .fault_detect_en(fde));
  lss_ctl_model u_ctl (.clk(pclk), .shift_clk(shift_clk), .serial_in(serial_in),
    .latch_strobe(latch_strobe), .blank(blank));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic print_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic timeout();
    bad_count++;
    $display("[FAIL] wait expected done seen timeout");
    print_verdict();
  endtask : timeout
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) timeout();
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(what, 48'(x), 48'(d));
    chk("pslverr", 48'(xe), 48'(e));
  endtask : rd
  function automatic int exp_chan(input int k);
    int p;
    p = k / 3;
    return 3 * ((p % 2) ? 15 - p / 2 : p / 2) + k % 3;
  endfunction : exp_chan
  function automatic logic [48:0] fw(input logic [7:0] cmd, input logic [2:0] pk,
      input logic [6:0] r, input logic [6:0] g, input logic [6:0] b, input logic [1:0] sel);
    return {1'b1, cmd, 11'h0, sel, b, g, r, pk, 3'h0};
  endfunction : fw
  task automatic watch(input string what, input logic [47:0] fin);
    logic [47:0] prev;
    int k;
    int n;
    prev = sink;
    k = 0;
    n = 0;
    while (k < 48 && n < 800) begin
      @(negedge pclk);
      n++;
      for (int c = 0; c < 48; c++) begin
        if (sink[c] !== prev[c]) begin
          chk(what, 48'(exp_chan(k)), 48'(c));
          k++;
        end
      end
      prev = sink;
    end
    if (k < 48) timeout();
    chk(what, fin, sink);
  endtask : watch
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_reset();
    chk("sink", 48'h0, sink);
    chk("peak", 48'h0, 48'(peak));
    rd("onoff", ADDR_ONOFF_LO, 32'h0, 1'b0);
    rd("bright", ADDR_BRIGHT, 32'h007F7F7F, 1'b0);
    rd("unmapped", 8'h40, 32'h0, 1'b1);
    apb(1'b1, ADDR_STEP, 32'h1);
    rd("step", ADDR_STEP, 32'h1, 1'b0);
  endtask : s_reset
  task automatic s_stagger();
    u_ctl.send({1'b0, {48{1'b1}}});
    chk("blanked", 48'h0, sink);
    rd("onoff hi", ADDR_ONOFF_HI, 32'h0000FFFF, 1'b0);
    u_ctl.set_blank(1'b0);
    watch("turn on", {48{1'b1}});
    u_ctl.set_blank(1'b1);
    repeat (6) @(posedge pclk);
    chk("forced off", 48'h0, sink);
    rd("onoff kept", ADDR_ONOFF_LO, 32'hFFFFFFFF, 1'b0);
    u_ctl.set_blank(1'b0);
    watch("blank fall", {48{1'b1}});
    fork
      u_ctl.send(49'h0);
      watch("turn off", 48'h0);
    join
  endtask : s_stagger
  task automatic s_func();
    u_ctl.send(fw(8'h95, 3'h6, 7'h01, 7'h02, 7'h03, 2'h3));
    chk("bad cmd", 48'h7F, 48'(rb));
    u_ctl.send(fw(WRITE_CMD, 3'h5, 7'h12, 7'h34, 7'h56, 2'h0));
    chk("red", 48'h12, 48'(rb));
    chk("green", 48'h34, 48'(gb));
    chk("blue", 48'h56, 48'(bb));
    chk("peak once", 48'h0, 48'(peak));
    u_ctl.send(fw(WRITE_CMD, 3'h5, 7'h7F, 7'h00, 7'h7F, 2'h0));
    chk("peak twice", 48'h5, 48'(peak));
    chk("green", 48'h00, 48'(gb));
    u_ctl.send(fw(WRITE_CMD, 3'h7, 7'h7F, 7'h00, 7'h7F, 2'h0));
    u_ctl.send(fw(WRITE_CMD, 3'h7, 7'h7F, 7'h00, 7'h7F, 2'h0));
    chk("peak top", 48'h7, 48'(peak));
  endtask : s_func
  task automatic s_psave();
    u_ctl.send(fw(WRITE_CMD, 3'h7, 7'h7F, 7'h00, 7'h7F, 2'h3));
    chk("ps sel 11", 48'h1, 48'(ps));
    chk("fault en", 48'h0, 48'(fde));
    u_ctl.send({1'b0, 48'h3});
    repeat (64) @(posedge pclk);
    rd("status", ADDR_STATUS, 32'h7D, 1'b0);
    rd("latch works", ADDR_ONOFF_LO, 32'h3, 1'b0);
    u_ctl.send(fw(WRITE_CMD, 3'h7, 7'h7F, 7'h00, 7'h7F, 2'h0));
    chk("ps sel 00", 48'h0, 48'(ps));
    u_ctl.send(fw(WRITE_CMD, 3'h7, 7'h7F, 7'h00, 7'h7F, 2'h1));
    u_ctl.send(49'h0);
    chk("ps enter 01", 48'h1, 48'(ps));
    u_ctl.pulse_clk();
    repeat (4) @(posedge pclk);
    chk("ps exit 01", 48'h0, 48'(ps));
    u_ctl.send(fw(WRITE_CMD, 3'h7, 7'h7F, 7'h00, 7'h7F, 2'h2));
    u_ctl.send(49'h0);
    chk("ps enter 10", 48'h1, 48'(ps));
    u_ctl.pulse_clk();
    repeat (4) @(posedge pclk);
    chk("ps hold 10", 48'h1, 48'(ps));
    u_ctl.send({1'b0, 48'h1});
    chk("ps exit 10", 48'h0, 48'(ps));
  endtask : s_psave
  task automatic s_midreset();
    apb(1'b1, ADDR_STEP, 32'hFFFFFF02);
    rd("step low byte", ADDR_STEP, 32'h2, 1'b0);
    apb(1'b1, 8'h44, 32'hA5A55A5A);
    chk("wr unmapped", 48'h1, 48'(e));
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("peak rst", 48'h0, 48'(peak));
    chk("sink rst", 48'h0, sink);
    rd("onoff rst", ADDR_ONOFF_HI, 32'h0, 1'b0);
    rd("step rst", ADDR_STEP, 32'(STEP_RST), 1'b0);
    apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
    rd("status ro", ADDR_STATUS, 32'h0, 1'b0);
  endtask : s_midreset
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_stagger();
    s_func();
    s_psave();
    s_midreset();
    print_verdict();
  end
endmodule : test_lss_top
